// *** adc_result_interrupt_regs_test.sv ***
`timescale 1ns/1ns
module adc_result_interrupt_regs_test;
  import arir_pkg::*;

  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  logic                mclk;
  logic                arst_n;
  arir_bus_type        bus;
  logic [DATA_W-1:0]   rdata;
  logic                conv_valid;
  logic [SAMPLE_W-1:0] conv_sample;
  logic [DATA_W-1:0]   conv_wide;
  logic                window_hit;
  logic                enable_sync;
  logic                sync_core_done;
  logic [DATA_W-1:0]   window_lower;
  logic [DATA_W-1:0]   window_upper;
  logic                irq;
  logic                rd_seen;
  logic [DATA_W-1:0]   exp_q[$];
  string               name_q[$];
  int                  miscompares;
  int                  total_checks;
  logic [DATA_W-1:0]   val;
  logic [DATA_W-1:0]   wide;
  logic [SAMPLE_W-1:0] smp;
  logic [7:0]          taddr;
  logic [7:0]          reset_addrs[10];

  arir_regs u_dut (
    .i_mclk           (mclk),
    .i_arst_n         (arst_n),
    .i_bus            (bus),
    .o_rdata          (rdata),
    .i_conv_valid     (conv_valid),
    .i_conv_sample    (conv_sample),
    .i_conv_wide      (conv_wide),
    .i_window_hit     (window_hit),
    .i_sync_core_done (sync_core_done),
    .i_enable_sync    (enable_sync),
    .o_window_lower   (window_lower),
    .o_window_upper   (window_upper),
    .o_irq            (irq)
  );

  // ----------------------------------------------------------------------
  // Clock and shared tasks
  // ----------------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [DATA_W-1:0] seen,
                       input logic [DATA_W-1:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [DATA_W-1:0] d);
    bus.addr  <= a;
    bus.wdata <= d;
    bus.write <= 1'b1;
    @(posedge mclk);
    bus.write <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [DATA_W-1:0] exp);
    bus.addr <= a;
    bus.read <= 1'b1;
    exp_q.push_back(exp);
    name_q.push_back($sformatf("register %h", a));
    @(posedge mclk);
    bus.read <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic conv(input logic [SAMPLE_W-1:0] s, input logic [DATA_W-1:0] w);
    conv_valid  <= 1'b1;
    conv_sample <= s;
    conv_wide   <= w;
    @(posedge mclk);
    conv_valid <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic irq_chk(input logic exp);
    @(negedge mclk);
    check("irq", {15'h0000, irq}, {15'h0000, exp});
    @(posedge mclk);
  endtask

  task automatic conv_case(input logic [DATA_W-1:0] ctrl, input logic [DATA_W-1:0] gain,
                           input logic [SAMPLE_W-1:0] s, input logic [DATA_W-1:0] w,
                           input logic [DATA_W-1:0] exp);
    wr(ADDR_GAIN_CORR, gain);
    wr(ADDR_CONTROL_B, ctrl);
    conv(s, w);
    rd(ADDR_RESULT, exp);
    rd(ADDR_INT_FLAGS, 16'h0000);
  endtask

  // ----------------------------------------------------------------------
  // Read data monitor
  // ----------------------------------------------------------------------
  always @(posedge mclk) begin
    rd_seen <= bus.read;
  end

  always @(negedge mclk) begin
    if (rd_seen === 1'b1 && exp_q.size() > 0) begin
      check(name_q.pop_front(), rdata, exp_q.pop_front());
    end
  end

  initial begin
    repeat (6000) @(posedge mclk);
    miscompares++;
    conclude();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    arst_n      = 1'b0;
    bus         = '0;
    conv_valid  = 1'b0;
    conv_sample = 12'h000;
    conv_wide   = 16'h0000;
    window_hit  = 1'b0;
    enable_sync = 1'b0;
    sync_core_done = 1'b0;
    rd_seen     = 1'b0;
    miscompares = 0;
    total_checks = 0;
    reset_addrs = '{8'h16, 8'h17, 8'h18, 8'h19, 8'h1a, 8'h1c, 8'h20, 8'h24, 8'h26, 8'h30};
    void'($urandom(15530));
    repeat (8) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    foreach (reset_addrs[i]) begin
      rd(reset_addrs[i], 16'h0000);
    end
    wr(ADDR_IEN_SET, 16'h0005);
    rd(ADDR_IEN_SET, 16'h0005);
    rd(ADDR_IEN_CLEAR, 16'h0005);
    wr(ADDR_IEN_SET, 16'h000a);
    rd(ADDR_IEN_SET, 16'h000f);
    wr(ADDR_IEN_CLEAR, 16'h0003);
    rd(ADDR_IEN_CLEAR, 16'h000c);
    smp = 12'($urandom);
    conv(smp, 16'h0000);
    rd(ADDR_INT_FLAGS, 16'h0001);
    irq_chk(1'b0);
    wr(ADDR_IEN_SET, 16'h0001);
    irq_chk(1'b1);
    rd(ADDR_RESULT, {4'h0, smp});
    rd(ADDR_INT_FLAGS, 16'h0000);
    irq_chk(1'b0);
    wr(ADDR_IEN_CLEAR, 16'h0001);
    wr(ADDR_IEN_SET, 16'h0002);
    conv(12'($urandom), 16'h0000);
    smp = 12'($urandom);
    conv(smp, 16'h0000);
    rd(ADDR_INT_FLAGS, 16'h0003);
    irq_chk(1'b1);
    rd(ADDR_RESULT, {4'h0, smp});
    rd(ADDR_INT_FLAGS, 16'h0002);
    wr(ADDR_INT_FLAGS, 16'h0000);
    rd(ADDR_INT_FLAGS, 16'h0002);
    wr(ADDR_INT_FLAGS, 16'h0002);
    rd(ADDR_INT_FLAGS, 16'h0000);
    irq_chk(1'b0);
    wr(ADDR_IEN_CLEAR, 16'h0002);
    // Clear lands in the cycle the result arrives.
    smp = 12'($urandom);
    conv_valid  <= 1'b1;
    conv_sample <= smp;
    @(posedge mclk);
    conv_valid <= 1'b0;
    bus.addr   <= ADDR_INT_FLAGS;
    bus.wdata  <= 16'h0001;
    bus.write  <= 1'b1;
    @(posedge mclk);
    bus.write  <= 1'b0;
    @(posedge mclk);
    rd(ADDR_INT_FLAGS, 16'h0001);
    rd(ADDR_RESULT, {4'h0, smp});
    wr(ADDR_GAIN_CORR, 16'h0fff);
    rd(ADDR_GAIN_CORR, 16'h0fff);
    smp = 12'($urandom);
    conv_case(16'h0001, 16'h0800, smp, 16'h0000, {smp, 4'h0});
    wide = 16'($urandom);
    conv_case(16'h0004, 16'h0800, smp, wide, wide);
    conv_case(16'h0002, 16'h0800, smp, 16'h0000, {4'h0, smp});
    // Signed offset, then saturation at zero.
    wr(ADDR_OFFSET_CORR, 16'h0ff0);
    rd(ADDR_OFFSET_CORR, 16'h0ff0);
    conv_case(16'h0002, 16'h0800, smp & 12'h7ff, 16'h0000,
              {4'h0, (smp & 12'h7ff) + 12'h010});
    wr(ADDR_OFFSET_CORR, 16'h0010);
    conv_case(16'h0002, 16'h0800, 12'h005, 16'h0000, 16'h0000);
    wr(ADDR_OFFSET_CORR, 16'h0000);
    smp = smp & 12'hffe;
    conv_case(16'h0002, 16'h0400, smp, 16'h0000, {5'h00, smp[11:1]});
    wr(ADDR_CONTROL_B, 16'h0000);
    irq_chk(1'b0);
    window_hit <= 1'b1;
    @(posedge mclk);
    window_hit <= 1'b0;
    repeat (2) @(posedge mclk);
    rd(ADDR_INT_FLAGS, 16'h0004);
    irq_chk(1'b1);
    rd(ADDR_RESULT, {5'h00, smp[11:1]});
    rd(ADDR_INT_FLAGS, 16'h0000);
    irq_chk(1'b0);
    for (int i = 0; i < 2; i++) begin
      taddr = (i == 0) ? ADDR_WIN_LOWER : ADDR_WIN_UPPER;
      val = 16'($urandom);
      wr(taddr, val);
      rd(ADDR_SYNC_STATUS, 16'h0080);
      repeat (6) @(posedge mclk);
      rd(ADDR_SYNC_STATUS, 16'h0000);
      rd(ADDR_INT_FLAGS, 16'h0008);
      irq_chk(1'b1);
      check("threshold", (i == 0) ? window_lower : window_upper, val);
      rd(taddr, val);
      wr(ADDR_INT_FLAGS, 16'h0000);
      rd(ADDR_INT_FLAGS, 16'h0008);
      wr(ADDR_INT_FLAGS, 16'h0008);
      rd(ADDR_INT_FLAGS, 16'h0000);
      irq_chk(1'b0);
    end
    wr(ADDR_SYNC_STATUS, 16'h0080);
    rd(ADDR_SYNC_STATUS, 16'h0000);
    wr(ADDR_RESULT, 16'hffff);
    rd(ADDR_RESULT, {5'h00, smp[11:1]});
    enable_sync <= 1'b1;
    @(posedge mclk);
    enable_sync <= 1'b0;
    rd(ADDR_SYNC_STATUS, 16'h0080);
    repeat (8) @(posedge mclk);
    rd(ADDR_SYNC_STATUS, 16'h0000);
    rd(ADDR_INT_FLAGS, 16'h0000);
    irq_chk(1'b0);
    // Early completion reported by the converter.
    wr(ADDR_WIN_LOWER, val);
    sync_core_done <= 1'b1;
    @(posedge mclk);
    sync_core_done <= 1'b0;
    rd(ADDR_SYNC_STATUS, 16'h0000);
    rd(ADDR_INT_FLAGS, 16'h0008);
    irq_chk(1'b1);
    wr(ADDR_INT_FLAGS, 16'h0008);
    rd(ADDR_INT_FLAGS, 16'h0000);
    irq_chk(1'b0);
    repeat (2) @(posedge mclk);
    conclude();
  end

endmodule

// *** arir_corrector.sv ***
`timescale 1ns/1ns
module arir_corrector
  import arir_pkg::*;
(
  input  wire logic                i_mclk,
  input  wire logic                i_arst_n,
  input  wire logic                i_valid,
  input  wire logic [SAMPLE_W-1:0] i_sample,
  input  wire logic [DATA_W-1:0]   i_wide,
  input  wire logic                i_oversample,
  input  wire arir_corr_type       i_cfg,
  output logic                     o_valid,
  output logic [DATA_W-1:0]        o_result
);

  logic signed [CORR_W+1:0]  offs_sum;
  logic        [CORR_W-1:0]  offs_sat;
  logic        [2*CORR_W-1:0] product;
  logic        [CORR_W:0]    scaled;
  logic        [CORR_W-1:0]  corrected;
  logic        [DATA_W-1:0]  placed;

  // ----------------------------------------------------------------------
  // Correction and placement
  // ----------------------------------------------------------------------
  always_comb begin
    // [R23] offset subtraction
    offs_sum = $signed({2'b00, i_sample}) - $signed({{2{i_cfg.offset[CORR_W-1]}}, i_cfg.offset});
    if (offs_sum < 0) begin
      offs_sat = '0;
    end else if (offs_sum > $signed({2'b00, SAMPLE_MAX})) begin
      offs_sat = SAMPLE_MAX;
    end else begin
      offs_sat = offs_sum[CORR_W-1:0];
    end
    // [R20] gain scaling
    product = offs_sat * i_cfg.gain;
    scaled  = product[GAIN_FRAC_W+CORR_W:GAIN_FRAC_W];
    if (scaled > {1'b0, SAMPLE_MAX}) begin
      corrected = SAMPLE_MAX;
    end else begin
      corrected = scaled[CORR_W-1:0];
    end
    if (!i_cfg.corr_en) begin
      corrected = i_sample;
    end
    // [R15] oversampled full width
    if (i_oversample) begin
      placed = i_wide;
    // [R13] left alignment
    end else if (i_cfg.left_align) begin
      placed = {corrected, {LEFT_SHIFT{1'b0}}};
    // [R14] right alignment
    end else begin
      placed = {{LEFT_SHIFT{1'b0}}, corrected};
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_result <= RESET_VALUE;
      o_valid  <= 1'b0;
    end else begin
      o_valid <= i_valid;
      if (i_valid) begin
        o_result <= placed;
      end
    end
  end

endmodule

// *** arir_pkg.sv ***
package arir_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_CONTROL_B   = 8'h01;
  localparam logic [7:0] ADDR_IEN_CLEAR   = 8'h16;
  localparam logic [7:0] ADDR_IEN_SET     = 8'h17;
  localparam logic [7:0] ADDR_INT_FLAGS   = 8'h18;
  localparam logic [7:0] ADDR_SYNC_STATUS = 8'h19;
  localparam logic [7:0] ADDR_RESULT      = 8'h1a;
  localparam logic [7:0] ADDR_WIN_LOWER   = 8'h1c;
  localparam logic [7:0] ADDR_WIN_UPPER   = 8'h20;
  localparam logic [7:0] ADDR_GAIN_CORR   = 8'h24;
  localparam logic [7:0] ADDR_OFFSET_CORR = 8'h26;

  // ----------------------------------------------------------------------
  // Field positions and widths
  // ----------------------------------------------------------------------
  localparam int          FLAG_W         = 4;
  localparam int          BIT_CONV_DONE  = 0;
  localparam int          BIT_OVERRUN    = 1;
  localparam int          BIT_WIN_MATCH  = 2;
  localparam int          BIT_SYNC_DONE  = 3;
  localparam int          BIT_SYNC_BUSY  = 7;
  localparam int          BIT_LEFT_ALIGN = 0;
  localparam int          BIT_CORR_EN    = 1;
  localparam int          BIT_OVERSAMPLE = 2;
  localparam int          CORR_W         = 12;
  localparam int          SAMPLE_W       = 12;
  localparam int          DATA_W         = 16;
  localparam int          GAIN_FRAC_W    = 11;
  localparam int          LEFT_SHIFT     = 4;
  localparam logic [15:0] RESET_VALUE    = 16'h0000;
  localparam logic [11:0] SAMPLE_MAX     = 12'hfff;

  // ----------------------------------------------------------------------
  // Synchroniser timing
  // ----------------------------------------------------------------------
  localparam int          SYNC_STAGES    = 2;
  localparam logic [1:0]  SYNC_CNT_LAST  = 2'h3;

  // ----------------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        write;
    logic        read;
  } arir_bus_type;

  typedef struct packed {
    logic        left_align;
    logic        corr_en;
    logic [11:0] gain;
    logic [11:0] offset;
  } arir_corr_type;

endpackage

// *** arir_regs.sv ***
// Strobed register access was decided locally.
`timescale 1ns/1ns
// Function
// [R1] Writing one to an enable-set bit sets that enable; zero does nothing.
// [R2] Busy falling sets sync-done flag unless caused by enable or reset.
// [R3] Sync-done flag clears only on write of one.
// [R4] Window flag sets one converter cycle after the window match.
// [R5] Window flag clears on write one or result read.
// [R6] Overrun flag sets when a result arrives before the previous is read.
// [R7] Overrun flag clears only on write one; result read leaves it.
// [R8] Conversion-done flag sets when a result becomes available.
// [R9] Conversion-done flag clears on write one or result read.
// [R10] Busy bit 7 rises at synchronisation start, falls at completion; read-only.
// [R11] Reserved bits read zero; software writes zero.
// [R12] Single-ended samples are 12 bits, placed by left-align control.
// [R13] Left-aligned result fills bits 15 to 4.
// [R14] Right-aligned unoversampled result fills bits 11 to 0.
// [R15] Oversampled result spans all 16 bits.
// [R16] Result read returns a value brought into the bus domain.
// [R17] Lower threshold register supplies the window lower bound.
// [R18] Upper threshold register supplies the window upper bound.
// [R19] Threshold writes cross to converter domain and start synchronisation.
// [R20] With correction on, results scale by 12-bit gain (1.11 fixed point).
// [R21] Gain codes range 0.1000... to 1.1111...; software keeps them there.
// [R22] Enable-clear writes of one clear enables; set and clear read alike.
// [R23] With correction on, a signed 12-bit offset is applied first.
// [R24] Interrupt request is high while any flag and its enable are set.
// [R25] A hardware set wins over a same-cycle software clear.
module arir_regs
  import arir_pkg::*;
(
  input  wire logic                i_mclk,
  input  wire logic                i_arst_n,
  input  wire arir_bus_type        i_bus,
  output logic [DATA_W-1:0]        o_rdata,
  input  wire logic                i_conv_valid,
  input  wire logic [SAMPLE_W-1:0] i_conv_sample,
  input  wire logic [DATA_W-1:0]   i_conv_wide,
  input  wire logic                i_window_hit,
  input  wire logic                i_sync_core_done,
  input  wire logic                i_enable_sync,
  output logic [DATA_W-1:0]        o_window_lower,
  output logic [DATA_W-1:0]        o_window_upper,
  output logic                     o_irq
);

  logic [FLAG_W-1:0] enable_reg;
  logic [FLAG_W-1:0] flags_reg;
  logic [FLAG_W-1:0] flags_next;
  logic [FLAG_W-1:0] set_evt;
  logic [FLAG_W-1:0] clr_evt;
  logic [2:0]        ctrl_reg;
  logic [11:0]       gain_reg;
  logic [11:0]       offset_reg;
  logic              unread_reg;
  logic              win_hit_reg;
  logic              enable_sync_reg;
  logic              busy;
  logic              busy_q;
  logic              sync_done;
  logic              thr_write;
  logic              result_read;
  logic              res_valid;
  logic [DATA_W-1:0] res_value;
  logic [DATA_W-1:0] rdata_next;
  arir_corr_type     corr_cfg;

  assign thr_write   = i_bus.write &&
                       (i_bus.addr == ADDR_WIN_LOWER || i_bus.addr == ADDR_WIN_UPPER);
  assign result_read = i_bus.read && i_bus.addr == ADDR_RESULT;
  assign corr_cfg    = '{left_align: ctrl_reg[BIT_LEFT_ALIGN],
                         corr_en:    ctrl_reg[BIT_CORR_EN],
                         gain:       gain_reg,
                         offset:     offset_reg};

  // ----------------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------------
  // [R12] sample path
  arir_corrector u_corr (
    .i_mclk       (i_mclk),
    .i_arst_n     (i_arst_n),
    .i_valid      (i_conv_valid),
    .i_sample     (i_conv_sample),
    .i_wide       (i_conv_wide),
    .i_oversample (ctrl_reg[BIT_OVERSAMPLE]),
    .i_cfg        (corr_cfg),
    .o_valid      (res_valid),
    .o_result     (res_value)
  );

  // [R19] threshold sync start
  arir_sync_tracker u_sync (
    .i_mclk      (i_mclk),
    .i_arst_n    (i_arst_n),
    .i_start     (thr_write || i_enable_sync),
    .i_core_done (i_sync_core_done),
    .o_busy      (busy),
    .o_done      (sync_done)
  );

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_window_lower <= RESET_VALUE;
      o_window_upper <= RESET_VALUE;
      gain_reg       <= '0;
      offset_reg     <= '0;
      ctrl_reg       <= '0;
    end else if (i_bus.write) begin
      case (i_bus.addr)
        // [R17] lower bound
        ADDR_WIN_LOWER:   o_window_lower <= i_bus.wdata;
        // [R18] upper bound
        ADDR_WIN_UPPER:   o_window_upper <= i_bus.wdata;
        // [R21] gain field store
        ADDR_GAIN_CORR:   gain_reg       <= i_bus.wdata[CORR_W-1:0];
        ADDR_OFFSET_CORR: offset_reg     <= i_bus.wdata[CORR_W-1:0];
        ADDR_CONTROL_B:   ctrl_reg       <= i_bus.wdata[2:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt enables
  // ----------------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      enable_reg <= '0;
    end else if (i_bus.write && i_bus.addr == ADDR_IEN_SET) begin
      // [R1] write-one set
      enable_reg <= enable_reg | i_bus.wdata[FLAG_W-1:0];
    end else if (i_bus.write && i_bus.addr == ADDR_IEN_CLEAR) begin
      // [R22] write-one clear
      enable_reg <= enable_reg & ~i_bus.wdata[FLAG_W-1:0];
    end
  end

  // ----------------------------------------------------------------------
  // Event detection
  // ----------------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      busy_q          <= 1'b0;
      win_hit_reg     <= 1'b0;
      unread_reg      <= 1'b0;
      enable_sync_reg <= 1'b0;
    end else begin
      busy_q      <= busy;
      // [R4] one cycle delay
      win_hit_reg <= i_window_hit;
      if (i_enable_sync) begin
        enable_sync_reg <= 1'b1;
      end else if (!busy) begin
        enable_sync_reg <= 1'b0;
      end
      if (res_valid) begin
        unread_reg <= 1'b1;
      end else if (result_read) begin
        unread_reg <= 1'b0;
      end
    end
  end

  always_comb begin
    set_evt = '0;
    clr_evt = '0;
    // [R2] busy falling edge
    set_evt[BIT_SYNC_DONE] = busy_q && !busy && sync_done && !enable_sync_reg;
    set_evt[BIT_WIN_MATCH] = win_hit_reg;
    // [R6] unread overwrite
    set_evt[BIT_OVERRUN]   = res_valid && unread_reg && !result_read;
    // [R8] result available
    set_evt[BIT_CONV_DONE] = res_valid;
    if (i_bus.write && i_bus.addr == ADDR_INT_FLAGS) begin
      // [R3] write-one clear
      clr_evt = i_bus.wdata[FLAG_W-1:0];
    end
    if (result_read) begin
      // [R5] read clears window
      clr_evt[BIT_WIN_MATCH] = 1'b1;
      // [R9] read clears done
      clr_evt[BIT_CONV_DONE] = 1'b1;
    end
    // [R7] read leaves overrun
    // [R25] set over clear
    flags_next = (flags_reg & ~clr_evt) | set_evt;
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      flags_reg <= '0;
    end else begin
      flags_reg <= flags_next;
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt and read data
  // ----------------------------------------------------------------------
  // [R24] flag and enable
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(flags_next & enable_reg);
    end
  end

  always_comb begin
    rdata_next = '0;
    // [R11] reserved read zero
    case (i_bus.addr)
      ADDR_IEN_CLEAR,
      ADDR_IEN_SET:     rdata_next[FLAG_W-1:0]   = enable_reg;
      ADDR_INT_FLAGS:   rdata_next[FLAG_W-1:0]   = flags_reg;
      ADDR_SYNC_STATUS: rdata_next[BIT_SYNC_BUSY] = busy;
      // [R16] bus-domain result
      ADDR_RESULT:      rdata_next               = res_value;
      ADDR_WIN_LOWER:   rdata_next               = o_window_lower;
      ADDR_WIN_UPPER:   rdata_next               = o_window_upper;
      ADDR_GAIN_CORR:   rdata_next[CORR_W-1:0]   = gain_reg;
      ADDR_OFFSET_CORR: rdata_next[CORR_W-1:0]   = offset_reg;
      ADDR_CONTROL_B:   rdata_next[2:0]          = ctrl_reg;
      default:          rdata_next               = '0;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rdata <= '0;
    end else if (i_bus.read) begin
      o_rdata <= rdata_next;
    end else begin
      o_rdata <= '0;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  property p_enable_set;
    @(posedge i_mclk) disable iff (!i_arst_n)
      (i_bus.write && i_bus.addr == ADDR_IEN_SET) |=>
        ((enable_reg & $past(i_bus.wdata[FLAG_W-1:0])) == $past(i_bus.wdata[FLAG_W-1:0]));
  endproperty
  a_enable_set: assert property (p_enable_set) else $error("enable set failed"); // [R1]

  property p_enable_clear;
    @(posedge i_mclk) disable iff (!i_arst_n)
      (i_bus.write && i_bus.addr == ADDR_IEN_CLEAR) |=>
        ((enable_reg & $past(i_bus.wdata[FLAG_W-1:0])) == '0);
  endproperty
  a_enable_clear: assert property (p_enable_clear) else $error("enable clear failed"); // [R22]

  property p_win_delay;
    @(posedge i_mclk) disable iff (!i_arst_n)
      i_window_hit |-> ##2 flags_reg[BIT_WIN_MATCH];
  endproperty
  a_win_delay: assert property (p_win_delay) else $error("window flag late"); // [R4]

  property p_done_set;
    @(posedge i_mclk) disable iff (!i_arst_n)
      res_valid |=> flags_reg[BIT_CONV_DONE];
  endproperty
  a_done_set: assert property (p_done_set) else $error("done flag missing"); // [R8]

  property p_read_clear;
    @(posedge i_mclk) disable iff (!i_arst_n)
      (result_read && !res_valid && !win_hit_reg) |=>
        (!flags_reg[BIT_CONV_DONE] && !flags_reg[BIT_WIN_MATCH]);
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("read did not clear"); // [R9]

  property p_overrun_keep;
    @(posedge i_mclk) disable iff (!i_arst_n)
      (flags_reg[BIT_OVERRUN] && !(i_bus.write && i_bus.addr == ADDR_INT_FLAGS)) |=>
        flags_reg[BIT_OVERRUN];
  endproperty
  a_overrun_keep: assert property (p_overrun_keep) else $error("overrun lost"); // [R7]

  property p_overrun_set;
    @(posedge i_mclk) disable iff (!i_arst_n)
      (res_valid && unread_reg && !result_read) |=> flags_reg[BIT_OVERRUN];
  endproperty
  a_overrun_set: assert property (p_overrun_set) else $error("overrun not set"); // [R6]

  property p_sync_keep;
    @(posedge i_mclk) disable iff (!i_arst_n)
      (flags_reg[BIT_SYNC_DONE] && !(i_bus.write && i_bus.addr == ADDR_INT_FLAGS)) |=>
        flags_reg[BIT_SYNC_DONE];
  endproperty
  a_sync_keep: assert property (p_sync_keep) else $error("sync flag lost"); // [R3]

  property p_busy_start;
    @(posedge i_mclk) disable iff (!i_arst_n)
      thr_write |=> busy ##[1:5] !busy;
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("busy misbehaved"); // [R19]

  property p_irq;
    @(posedge i_mclk) disable iff (!i_arst_n)
      ##1 (o_irq == |($past(flags_next) & $past(enable_reg)));
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch"); // [R24]

  property p_stat_rsvd;
    @(posedge i_mclk) disable iff (!i_arst_n)
      (i_bus.read && i_bus.addr == ADDR_SYNC_STATUS) |=>
        (o_rdata[BIT_SYNC_BUSY-1:0] == '0 && o_rdata[DATA_W-1:BIT_SYNC_BUSY+1] == '0);
  endproperty
  a_stat_rsvd: assert property (p_stat_rsvd) else $error("status reserved set"); // [R11]

  property p_flag_rsvd;
    @(posedge i_mclk) disable iff (!i_arst_n)
      (i_bus.read && i_bus.addr == ADDR_INT_FLAGS) |=> (o_rdata[DATA_W-1:FLAG_W] == '0);
  endproperty
  a_flag_rsvd: assert property (p_flag_rsvd) else $error("flag reserved set"); // [R11]

  property p_sync_quiet;
    @(posedge i_mclk) disable iff (!i_arst_n)
      (busy_q && !busy && enable_sync_reg && !flags_reg[BIT_SYNC_DONE]) |=>
        !flags_reg[BIT_SYNC_DONE];
  endproperty
  a_sync_quiet: assert property (p_sync_quiet) else $error("sync flag on enable"); // [R2]

  c_overrun:  cover property (@(posedge i_mclk) disable iff (!i_arst_n) set_evt[BIT_OVERRUN]);
  c_sync:     cover property (@(posedge i_mclk) disable iff (!i_arst_n) set_evt[BIT_SYNC_DONE]);
  c_irq:      cover property (@(posedge i_mclk) disable iff (!i_arst_n) $rose(o_irq));
  c_rd_clear: cover property (@(posedge i_mclk) disable iff (!i_arst_n)
                              result_read && flags_reg[BIT_CONV_DONE]);

endmodule

// *** arir_sync_tracker.sv ***
`timescale 1ns/1ns
module arir_sync_tracker
  import arir_pkg::*;
(
  input  wire logic i_mclk,
  input  wire logic i_arst_n,
  input  wire logic i_start,
  input  wire logic i_core_done,
  output logic      o_busy,
  output logic      o_done
);

  logic [1:0] cnt_reg;

  // ----------------------------------------------------------------------
  // Busy tracking
  // ----------------------------------------------------------------------
  // [R10] busy while crossing
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_busy  <= 1'b0;
      cnt_reg <= '0;
      o_done  <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (i_start) begin
        o_busy  <= 1'b1;
        cnt_reg <= '0;
      end else if (o_busy) begin
        cnt_reg <= cnt_reg + 2'h1;
        if (cnt_reg == SYNC_CNT_LAST || i_core_done) begin
          o_busy <= 1'b0;
          o_done <= 1'b1;
        end
      end
    end
  end

endmodule
